// ### design/wake_pkg.sv
// Purpose: shared constants for the wake-up / watchdog / reset block
// Assumes: 10 MHz clock, 60 k timing resistor by default
// Notes: times in their own units, cycle counts derived from them
package wake_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 100;
  // timing resistor in ohms
  localparam int unsigned R_DELAY_OHM = 60_000;
  // seconds per ohm scaled by 1e12 (ps per ohm)
  localparam longint unsigned WAKE_PS_PER_OHM = 417_000;
  localparam longint unsigned RST_PS_PER_OHM = 52_100;
  localparam longint unsigned FIRST_PS_PER_OHM = 208_000;
  // derived cycle counts (ps / 100000 ps per cycle)
  localparam longint unsigned PS_PER_CYCLE = 100_000;
  localparam int unsigned WAKE_CYCLES =
    int'((WAKE_PS_PER_OHM * R_DELAY_OHM) / PS_PER_CYCLE);
  localparam int unsigned RST_DELAY_CYCLES =
    int'((RST_PS_PER_OHM * R_DELAY_OHM) / PS_PER_CYCLE);
  localparam int unsigned FIRST_WAKE_CYCLES =
    int'((FIRST_PS_PER_OHM * R_DELAY_OHM) / PS_PER_CYCLE);
  // duty cycle in percent
  localparam int unsigned DUTY_PCT = 50;
  // reset pulse width for a missed watchdog edge
  localparam int unsigned WD_PULSE_US = 20;
  localparam int unsigned WD_PULSE_CYCLES = (WD_PULSE_US * 1000) / CLK_NS;
  localparam int unsigned CNT_W = 24;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_FIRST = 2'b01,
    ST_RUN   = 2'b10
  } wake_state_t;
endpackage

// ### design/wake_counter.sv
// Purpose: loadable down counter with terminal flag
// Assumes: synchronous reset
// Notes: done is high while count is zero
`timescale 1ns/1ps
`default_nettype none
module wake_counter #(
  parameter int unsigned WIDTH = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  // status
  output logic [WIDTH-1:0] count,
  output logic done
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  // refuse a counter too narrow to count down
  if (WIDTH < 2) begin : g_bad_width
    $error("wake_counter width too small");
  end

  // next count
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // register
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;
  assign done = (cnt_q == '0);
endmodule
`default_nettype wire

// ### design/wake_watchdog.sv
// Purpose: wake-up square wave, watchdog check and reset generation
// Assumes: all inputs synchronous to clk
// Notes: one counter serves every timed interval; a missed watchdog fall
//   gives a short reset pulse, then the first-wake delay runs again
//   without the full reset delay
//
// Summary of operation
// - wake output square wave, 50% duty
// - all intervals except the fixed 20 us reset pulse scale with timing resistor
// - 60k gives 25 ms period
// - only watchdog falling edges count
// - accepted edge forces wake low
// - further edges ignored until next period
// - missed edge gives reset pulse
// - power-up reset until output regulated
// - low output resets, then reset delay
// - low input supply forces reset
// - wake held low during reset
// - after reset, wake rises after delay
// - wake falls promptly after watchdog edge
// - wake falls promptly with reset
// - enable low shuts device down
`timescale 1ns/1ps
`default_nettype none
module wake_watchdog #(
  parameter int unsigned WAKE_CYC = wake_pkg::WAKE_CYCLES,
  parameter int unsigned RST_CYC = wake_pkg::RST_DELAY_CYCLES,
  parameter int unsigned FIRST_CYC = wake_pkg::FIRST_WAKE_CYCLES,
  parameter int unsigned PULSE_CYC = wake_pkg::WD_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // supply status and enable
  input wire logic enable,
  input wire logic out_in_reg,
  input wire logic vin_ok,
  // controller side
  input wire logic watchdog_input,
  output logic wake_out,
  output logic reset_n
);
  import wake_pkg::*;

  // counter loads: loading N-1 gives an interval of N clock cycles; the wake
  // output falls when the count passes the middle of the period
  localparam logic [CNT_W-1:0] WAKE_LD = CNT_W'(WAKE_CYC - 1);
  localparam logic [CNT_W-1:0] HIGH_LD = CNT_W'((WAKE_CYC * DUTY_PCT) / 100);
  localparam logic [CNT_W-1:0] RST_LD = CNT_W'(RST_CYC - 1);
  localparam logic [CNT_W-1:0] FIRST_LD = CNT_W'(FIRST_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_LD = CNT_W'(PULSE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks: every interval must fit the shared counter, and the
  // period must leave room for a high and a low half
  if (WAKE_CYC < 4 || WAKE_CYC >= (1 << CNT_W)) begin : g_bad_wake
    $error("bad wake period");
  end
  if (RST_CYC < 1 || RST_CYC >= (1 << CNT_W)) begin : g_bad_rst
    $error("bad reset delay");
  end
  if (FIRST_CYC < 1 || FIRST_CYC >= (1 << CNT_W)) begin : g_bad_first
    $error("bad first delay");
  end
  if (PULSE_CYC < 1 || PULSE_CYC >= (1 << CNT_W)) begin : g_bad_pulse
    $error("bad pulse width");
  end
  if (HIGH_LD == '0 || HIGH_LD >= WAKE_LD) begin : g_bad_duty
    $error("bad duty split");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  wake_state_t st_q, st_d;
  logic wd_prev_q, wd_prev_d;
  // boot_q: set by srst until the power-up reset delay has been loaded
  logic boot_q, boot_d;
  logic fed_q, fed_d;
  logic wake_q, wake_d;
  logic rst_q, rst_d;
  // shared counter interface
  logic ld;
  logic [CNT_W-1:0] ld_val;
  logic [CNT_W-1:0] cnt;
  logic cnt_done;
  logic supply_bad;
  logic wd_fall;

  // one down counter times reset delay, first delay, period and pulse;
  // every state change reloads it, so no interval inherits a stale count
  wake_counter #(
    .WIDTH(CNT_W)
  ) u_cnt (
    .clk(clk),
    .srst(srst),
    .load(ld),
    .load_val(ld_val),
    .count(cnt),
    .done(cnt_done)
  );

  // supply faults: enable low, output out of regulation, input too low;
  // any one of them is a reset condition on its own
  assign supply_bad = !enable || !out_in_reg || !vin_ok;
  assign wd_fall = wd_prev_q && !watchdog_input;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog history: the pin idles high, so the history bit starts low and
  // a pin already held low when srst ends does not count as a fall
  always_comb begin
    wd_prev_d = watchdog_input;
  end

  // history register
  always_ff @(posedge clk) begin
    if (srst) begin
      wd_prev_q <= 1'b0;
    end else begin
      wd_prev_q <= wd_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_d = st_q;
    fed_d = fed_q;
    wake_d = wake_q;
    rst_d = rst_q;
    boot_d = boot_q;
    ld = 1'b0;
    ld_val = RST_LD;
    case (st_q)
      ST_RESET: begin
        rst_d = 1'b1;
        wake_d = 1'b0;
        // after srst the counter is empty, so the first pass loads the full
        // delay; a supply fault keeps reloading it until the fault clears
        if (supply_bad || boot_q) begin
          ld = 1'b1;
          ld_val = RST_LD;
          boot_d = 1'b0;
        end else if (cnt_done) begin
          rst_d = 1'b0;
          st_d = ST_FIRST;
          ld = 1'b1;
          ld_val = FIRST_LD;
        end
      end
      // reset released: wait the first delay, then start the first period
      ST_FIRST: begin
        if (cnt_done) begin
          st_d = ST_RUN;
          wake_d = 1'b1;
          fed_d = 1'b0;
          ld = 1'b1;
          ld_val = WAKE_LD;
        end
      end
      // running: wake high for the first half unless a fall cuts it short
      ST_RUN: begin
        if (wd_fall && !fed_q) begin
          fed_d = 1'b1;
          wake_d = 1'b0;
        end else if (cnt == HIGH_LD) begin
          wake_d = 1'b0;
        end
        // period end: a fall seen on this very edge still counts as fed,
        // otherwise the missed fall turns into a short reset pulse
        if (cnt_done) begin
          if (fed_q || wd_fall) begin
            wake_d = 1'b1;
            fed_d = 1'b0;
            ld = 1'b1;
            ld_val = WAKE_LD;
          end else begin
            st_d = ST_RESET;
            rst_d = 1'b1;
            wake_d = 1'b0;
            ld = 1'b1;
            ld_val = PULSE_LD;
          end
        end
      end
      default: begin
        st_d = ST_RESET;
      end
    endcase
    // a supply fault overrides every state on the same edge, so reset and
    // the wake low are registered on the same clock edge that samples the fault
    if (supply_bad) begin
      st_d = ST_RESET;
      rst_d = 1'b1;
      wake_d = 1'b0;
      ld = 1'b1;
      ld_val = RST_LD;
    end
  end

  // state registers; srst holds reset asserted and wake low
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= ST_RESET;
      boot_q <= 1'b1;
      fed_q <= 1'b0;
      wake_q <= 1'b0;
      rst_q <= 1'b1;
    end else begin
      st_q <= st_d;
      boot_q <= boot_d;
      fed_q <= fed_d;
      wake_q <= wake_d;
      rst_q <= rst_d;
    end
  end

  // outputs come straight from flip-flops
  assign wake_out = wake_q;
  assign reset_n = !rst_q;
endmodule
`default_nettype wire

// ### test/wake_watchdog_assertions.sv
// Purpose: port checks for wake_watchdog
// Assumes: one clock, srst synchronous
// Notes: bound to the design top
`timescale 1ns/1ps
`default_nettype none
module wake_watchdog_chk (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // supplies and watchdog
  input wire logic enable,
  input wire logic out_in_reg,
  input wire logic vin_ok,
  input wire logic watchdog_input,
  // device outputs
  input wire logic wake_out,
  input wire logic reset_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_vin_low_rst: assert property (!vin_ok |=> !reset_n) else $error("vin");
  chk_reg_low_rst: assert property (!out_in_reg |=> !reset_n) else $error("reg");
  chk_en_low_rst: assert property (!enable |=> !reset_n) else $error("en");
  chk_rst_wake_low: assert property (!reset_n [*2] |-> !wake_out) else $error("wk");
  chk_fall_wake: assert property (wake_out && $fell(watchdog_input) |-> ##[1:2] !wake_out)
    else $error("fall");
  chk_first_delay: assert property ($rose(reset_n) |-> !wake_out [*8]) else $error("dly");
  chk_rise_ok: assert property ($rose(reset_n) |-> $past(vin_ok && out_in_reg && enable))
    else $error("rise");
  chk_wake_high: assert property ($rose(wake_out) |-> (wake_out || !reset_n) [*8])
    else $error("hi");
endmodule
bind wake_watchdog wake_watchdog_chk u_chk (.clk, .srst, .enable, .out_in_reg, .vin_ok,
  .watchdog_input, .wake_out, .reset_n);
`default_nettype wire

// ### test/mcu_model.sv
// Purpose: controller answering wake-ups
// Assumes: device outputs on clk
// Notes: feed low skips the watchdog pulse
`timescale 1ns/1ps
`default_nettype none
module mcu_model #(
  parameter int DLY = 60
) (
  // clock
  input wire logic clk,
  // device side
  input wire logic wake_out,
  input wire logic reset_n,
  input wire logic feed,
  output logic watchdog_input
);
  int cnt = 0;
  logic wake_q = 1'b0;
  logic wd_q = 1'b1;
  // idle high between pulses
  assign watchdog_input = wd_q;
  // pulse low DLY cycles after each wake rise
  always @(posedge clk) begin
    wake_q <= wake_out;
    if (!reset_n) cnt <= 0;
    else if (wake_out && !wake_q) cnt <= 1;
    else if (cnt != 0 && cnt < DLY + 4) cnt <= cnt + 1;
    wd_q <= !(feed && cnt >= DLY && cnt < DLY + 4);
  end
endmodule
`default_nettype wire

// ### test/tb_wake_watchdog.sv
// Purpose: self-checking bench for wake_watchdog
// Assumes: short timing parameters
// Notes: controller model feeds the watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, a) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", s, e, a); end end
module tb_wake_watchdog;
  localparam int W = 200, R = 5, F = 100, P = 3, D = 60;
  logic clk = 1'b0, srst = 1'b1, enable = 1'b1, out_in_reg = 1'b1, vin_ok = 1'b1;
  logic feed = 1'b1, watchdog_input, wake_out, reset_n;
  int miscompares = 0, n_checks = 0, cyc = 0, n;
  wake_watchdog #(.WAKE_CYC(W), .RST_CYC(R), .FIRST_CYC(F), .PULSE_CYC(P)) u_dut (.clk,
    .srst, .enable, .out_in_reg, .vin_ok, .watchdog_input, .wake_out, .reset_n);
  mcu_model #(.DLY(D)) u_mcu (.clk, .wake_out, .reset_n, .feed, .watchdog_input);
  // clock and hang guard
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  function automatic logic sig(int i);
    return i ? wake_out : reset_n;
  endfunction
  task automatic wt(input int i, input logic v, input int lim);
    n = 0;
    while (sig(i) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_powerup;
    repeat (6) @(posedge clk);
    `CHK("rst_n", 1'b0, reset_n)
    srst <= 1'b0;
    wt(0, 1'b1, R + 8);
    `CHK("rdly", 1'b1, n inside {[R:R+3]})
    wt(1, 1'b1, F + 8);
    `CHK("first", 1'b1, n inside {[F-2:F+2]})
  endtask
  task automatic t_fed;
    int hi;
    repeat (3) begin
      wt(1, 1'b0, W);
      hi = n;
      `CHK("cut", 1'b1, hi inside {[D:D+3]})
      wt(1, 1'b1, W);
      `CHK("period", 1'b1, hi + n inside {[W-2:W+2]})
      `CHK("fed", 1'b1, reset_n)
    end
  endtask
  task automatic t_miss;
    @(posedge clk) feed <= 1'b0;
    wt(1, 1'b0, W);
    `CHK("half", 1'b1, n inside {[W/2-2:W/2+1]})
    wt(0, 1'b0, W);
    `CHK("miss", 1'b1, n inside {[W/2-2:W/2+2]})
    `CHK("wlow", 1'b0, wake_out)
    @(posedge clk) feed <= 1'b1;
    wt(0, 1'b1, P + R + 8);
    wt(1, 1'b1, F + 8);
    `CHK("again", 1'b1, n inside {[F-2:F+2]})
  endtask
  task automatic t_fault;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {enable, out_in_reg, vin_ok} <= ~(3'b100 >> i);
      repeat (3) @(posedge clk);
      `CHK("frst", 1'b0, reset_n)
      `CHK("fwake", 1'b0, wake_out)
      {enable, out_in_reg, vin_ok} <= 3'b111;
      wt(0, 1'b1, R + 8);
      `CHK("recov", 1'b1, n inside {[R-1:R+3]})
      wt(1, 1'b1, F + 8);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    t_powerup();
    t_fed();
    t_miss();
    t_fault();
    tally_and_finish();
  end
endmodule
`default_nettype wire
